/* File: rtl/adcsc_format.sv */
// Purpose: formats a raw conversion result into the output word
// Assumes: raw result right-justified, 12 bits wide
// Notes:   reserved format codes fall back to the unsigned layout
`timescale 1ns/1ns
`default_nettype none
module adcsc_format (
	// selection
	input  wire logic                 twelve_i,
	input  wire logic [1:0]           output_format_sel_i,
	// data
	input  wire logic [11:0]          raw_i,
	output logic      [15:0]          word_o
);
	import adcsc_pkg::*;

	always_comb begin
		word_o = 16'h0000;
		if (twelve_i) begin
			if (output_format_sel_i == ADCSC_OUTPUT_FORMAT_SEL_SINT)
				word_o = {{4{~raw_i[11]}}, raw_i[11:0]};
			else
				word_o = {4'h0, raw_i[11:0]};
		end else begin
			if (output_format_sel_i == ADCSC_OUTPUT_FORMAT_SEL_SINT)
				word_o = {{6{~raw_i[9]}}, raw_i[9:0]};
			else
				word_o = {6'h00, raw_i[9:0]};
		end
	end
endmodule // adcsc_format
`default_nettype wire

/* File: rtl/adcsc_pkg.sv */
// Purpose: shared constants for the converter sample/convert control block
// Assumes: APB word registers, 16-bit control data in the low bits
// Notes:   field positions follow the control register layout
package adcsc_pkg;
	localparam logic [11:0] ADCSC_OFF_CTRL1    = 12'h000;
	localparam logic [11:0] ADCSC_OFF_CTRL2    = 12'h004;
	localparam logic [11:0] ADCSC_OFF_RESULT   = 12'h008;
	localparam logic [11:0] ADCSC_OFF_AUTOCNT  = 12'h00c;
	localparam int          ADCSC_ADDR_W       = 12;
	localparam int          ADCSC_REG_W        = 16;
	// control one fields
	localparam int          ADCSC_B_TWELVE     = 10;
	localparam int          ADCSC_B_OUTPUT_FORMAT_SEL_LO    = 8;
	localparam int          ADCSC_B_TRIG_LO    = 5;
	localparam int          ADCSC_B_SIMULTANEOUS_SAMPLE_EN     = 3;
	localparam int          ADCSC_B_AUTO       = 2;
	localparam int          ADCSC_B_SAMPLE     = 1;
	localparam int          ADCSC_B_DONE       = 0;
	// control two fields
	localparam int          ADCSC_B_CHANNEL_COUNT_SEL_LO    = 8;
	localparam logic [15:0] ADCSC_CTRL1_WMASK  = 16'h07ef;
	localparam logic [15:0] ADCSC_CTRL2_WMASK  = 16'h0300;
	localparam logic [15:0] ADCSC_RESET_VAL    = 16'h0000;
	localparam logic [1:0]  ADCSC_OUTPUT_FORMAT_SEL_UINT    = 2'h0;
	localparam logic [1:0]  ADCSC_OUTPUT_FORMAT_SEL_SINT    = 2'h1;
	localparam logic [2:0]  ADCSC_TRIG_SW      = 3'h0;
	localparam logic [2:0]  ADCSC_TRIG_PIN     = 3'h1;
	localparam logic [2:0]  ADCSC_TRIG_TMR_C   = 3'h2;
	localparam logic [2:0]  ADCSC_TRIG_TMR_E   = 3'h4;
	localparam logic [2:0]  ADCSC_TRIG_AUTO    = 3'h7;
	localparam logic [1:0]  ADCSC_CHANNEL_COUNT_SEL_ONE     = 2'h0;
	localparam logic [1:0]  ADCSC_CHANNEL_COUNT_SEL_TWO     = 2'h1;
	localparam logic [7:0]  ADCSC_AUTOCNT_RST  = 8'h10;
	localparam int          ADCSC_NUM_CH       = 4;
	typedef enum logic [1:0] {
		ADCSC_IDLE,
		ADCSC_SAMPLING,
		ADCSC_CONVERT
	} adcsc_state_e;
endpackage

/* File: rtl/adcsc_top.sv */
// Purpose: sample and conversion sequencing control with APB registers
// Assumes: converter core answers conv_start with conv_done and a result
// Notes:   APB slave answers with no wait states
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module adcsc_top #(
	parameter int AUTO_CNT_W = 8
) (
	// clock and reset
	input  wire logic                          CLK_I,
	input  wire logic                          RST_B_I,
	// apb slave
	input  wire logic                          PSEL_I,
	input  wire logic                          PENABLE_I,
	input  wire logic                          PWRITE_I,
	input  wire logic [adcsc_pkg::ADCSC_ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]                   PWDATA_I,
	output logic      [31:0]                   PRDATA_O,
	output logic                               PREADY_O,
	output logic                               PSLVERR_O,
	// trigger sources
	input  wire logic                          EXT_TRIG_PIN_I,
	input  wire logic                          TIMER_C_CMP_I,
	input  wire logic                          TIMER_E_CMP_I,
	// sample/hold amplifiers
	output logic      [adcsc_pkg::ADCSC_NUM_CH-1:0] SH_ACQUIRE_O,
	// converter core
	output logic                               CONV_START_O,
	output logic      [1:0]                    CONV_CH_O,
	input  wire logic                          CONV_DONE_I,
	input  wire logic [11:0]                   CONV_RESULT_I
);
	import adcsc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// register state
	logic                  twelve_bit_mode;
	logic [1:0]            output_format_sel;
	logic [2:0]            conversion_trigger_sel;
	logic                  simultaneous_sample_en;
	logic                  auto_sample_start;
	logic                  sample_enable;
	logic                  conv_done;
	logic [1:0]            channel_count_sel;
	logic [AUTO_CNT_W-1:0] auto_cnt_load;
	logic [15:0]           result_word;
	logic [15:0]           fmt_word;
	adcsc_state_e          state;
	logic [AUTO_CNT_W-1:0] auto_cnt;
	logic [1:0]            ch_idx;
	logic [1:0]            ch_last;
	logic                  pin_prev;
	logic                  pin_edge;
	logic                  hw_trig;
	logic                  sw_trig;
	logic                  start_conv;
	logic                  finish_all;
	logic                  wr_en;
	logic                  rd_en;
	logic                  wr_ctrl1;
	logic [15:0]           wdat;
	logic                  addr_ok;
	logic                  simultaneous_sample_en_eff;

	assign wr_en    = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd_en    = PSEL_I & ~PWRITE_I;
	assign wdat     = PWDATA_I[ADCSC_REG_W-1:0];
	assign wr_ctrl1 = wr_en & (PADDR_I == ADCSC_OFF_CTRL1);
	assign addr_ok  = (PADDR_I == ADCSC_OFF_CTRL1)
		| (PADDR_I == ADCSC_OFF_CTRL2)
		| (PADDR_I == ADCSC_OFF_RESULT)
		| (PADDR_I == ADCSC_OFF_AUTOCNT);
	// the bit is unimplemented in 12-bit mode
	assign simultaneous_sample_en_eff = simultaneous_sample_en & ~twelve_bit_mode;

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			twelve_bit_mode        <= 1'b0;
			output_format_sel      <= ADCSC_OUTPUT_FORMAT_SEL_UINT;
			conversion_trigger_sel <= ADCSC_TRIG_SW;
			simultaneous_sample_en <= 1'b0;
			auto_sample_start      <= 1'b0;
		end else if (wr_ctrl1) begin
			twelve_bit_mode        <= wdat[ADCSC_B_TWELVE];
			output_format_sel      <= wdat[ADCSC_B_OUTPUT_FORMAT_SEL_LO +: 2];
			conversion_trigger_sel <= wdat[ADCSC_B_TRIG_LO +: 3];
			simultaneous_sample_en <= wdat[ADCSC_B_SIMULTANEOUS_SAMPLE_EN]
				& ~wdat[ADCSC_B_TWELVE];
			auto_sample_start      <= wdat[ADCSC_B_AUTO];
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			channel_count_sel <= ADCSC_CHANNEL_COUNT_SEL_ONE;
			auto_cnt_load     <= AUTO_CNT_W'(ADCSC_AUTOCNT_RST);
		end else if (wr_en && PADDR_I == ADCSC_OFF_CTRL2) begin
			channel_count_sel <= wdat[ADCSC_B_CHANNEL_COUNT_SEL_LO +: 2];
		end else if (wr_en && PADDR_I == ADCSC_OFF_AUTOCNT) begin
			auto_cnt_load <= wdat[AUTO_CNT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// trigger selection
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			pin_prev <= 1'b0;
		else
			pin_prev <= EXT_TRIG_PIN_I;
	end
	assign pin_edge = EXT_TRIG_PIN_I & ~pin_prev;

	always_comb begin
		hw_trig = 1'b0;
		unique case (conversion_trigger_sel)
			ADCSC_TRIG_AUTO:  hw_trig = (auto_cnt == '0);
			ADCSC_TRIG_TMR_E: hw_trig = TIMER_E_CMP_I;
			ADCSC_TRIG_TMR_C: hw_trig = TIMER_C_CMP_I;
			ADCSC_TRIG_PIN:   hw_trig = pin_edge;
			default:          hw_trig = 1'b0;
		endcase
	end

	// software trigger: zero written over a set sample bit
	assign sw_trig = wr_ctrl1 & ~wdat[ADCSC_B_SAMPLE] & sample_enable
		& (conversion_trigger_sel == ADCSC_TRIG_SW);
	assign start_conv = (state == ADCSC_SAMPLING)
		& (sw_trig | (hw_trig
		& (conversion_trigger_sel != ADCSC_TRIG_SW)));

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			auto_cnt <= '0;
		else if (state != ADCSC_SAMPLING)
			auto_cnt <= auto_cnt_load;
		else if (auto_cnt != '0)
			auto_cnt <= auto_cnt - 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// channel sequencing
	always_comb begin
		ch_last = 2'h0;
		if (!twelve_bit_mode) begin
			if (channel_count_sel == ADCSC_CHANNEL_COUNT_SEL_TWO)
				ch_last = 2'h1;
			else if (channel_count_sel[1])
				ch_last = 2'h3;
		end
	end
	assign finish_all = (state == ADCSC_CONVERT) & CONV_DONE_I
		& (ch_idx == ch_last);

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state  <= ADCSC_IDLE;
			ch_idx <= 2'h0;
		end else begin
			unique case (state)
				ADCSC_IDLE: begin
					if (sample_enable)
						state <= ADCSC_SAMPLING;
				end
				ADCSC_SAMPLING: begin
					if (start_conv) begin
						state  <= ADCSC_CONVERT;
						ch_idx <= 2'h0;
					end else if (!sample_enable) begin
						state <= ADCSC_IDLE;
					end
				end
				ADCSC_CONVERT: begin
					if (finish_all) begin
						state  <= auto_sample_start ? ADCSC_SAMPLING
							: ADCSC_IDLE;
						ch_idx <= 2'h0;
					end else if (CONV_DONE_I) begin
						ch_idx <= ch_idx + 2'h1;
					end
				end
			endcase
		end
	end

	always_comb begin
		CONV_START_O = start_conv;
		// in either mode each next channel is started on the previous result
		if (state == ADCSC_CONVERT && CONV_DONE_I && !finish_all)
			CONV_START_O = 1'b1;
	end
	assign CONV_CH_O = (state == ADCSC_CONVERT && CONV_DONE_I)
		? ch_idx + 2'h1 : ch_idx;

	////////////////////////////////////////////////////////////////////////
	// sample enable and done
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			sample_enable <= 1'b0;
		else if (finish_all && auto_sample_start)
			sample_enable <= 1'b1;
		else if (start_conv)
			sample_enable <= 1'b0;
		else if (wr_ctrl1 && !auto_sample_start
			&& state != ADCSC_CONVERT)
			sample_enable <= wdat[ADCSC_B_SAMPLE];
	end

	// set beats clear; the clear has no other effect
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			conv_done <= 1'b0;
		else if (finish_all)
			conv_done <= 1'b1;
		else if (start_conv)
			conv_done <= 1'b0;
		else if (wr_ctrl1 && !wdat[ADCSC_B_DONE])
			conv_done <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// sample/hold drive
	genvar g;
	generate
		for (g = 0; g < ADCSC_NUM_CH; g++) begin : g_sh
			logic used;
			logic seq_turn;
			assign used = (2'(g) <= ch_last);
			// sequential: only channel a tracks the sample bit
			assign seq_turn = (g == 0);
			// simultaneous: all used channels track the sample bit
			// sequential: the other used channels stay in hold throughout, even in their conversion slot
			always_ff @(posedge CLK_I or negedge RST_B_I) begin
				if (!RST_B_I)
					SH_ACQUIRE_O[g] <= 1'b0;
				else
					SH_ACQUIRE_O[g] <= used & sample_enable
						& (simultaneous_sample_en_eff | seq_turn);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// result
	adcsc_format u_format (
		.twelve_i (twelve_bit_mode),
		.output_format_sel_i   (output_format_sel),
		.raw_i    (CONV_RESULT_I),
		.word_o   (fmt_word)
	);

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			result_word <= ADCSC_RESET_VAL;
		else if (state == ADCSC_CONVERT && CONV_DONE_I)
			result_word <= fmt_word;
	end

	////////////////////////////////////////////////////////////////////////
	// apb read
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			PRDATA_O <= 32'h0000_0000;
		else if (rd_en && !PENABLE_I) begin
			PRDATA_O <= 32'h0000_0000;
			unique case (PADDR_I)
				ADCSC_OFF_CTRL1: PRDATA_O[15:0] <= {5'h00,
					twelve_bit_mode, output_format_sel,
					conversion_trigger_sel, 1'b0, simultaneous_sample_en_eff,
					auto_sample_start, sample_enable, conv_done};
				ADCSC_OFF_CTRL2: PRDATA_O[ADCSC_B_CHANNEL_COUNT_SEL_LO +: 2] <=
					twelve_bit_mode ? 2'h0 : channel_count_sel;
				ADCSC_OFF_RESULT:  PRDATA_O[15:0] <= result_word;
				ADCSC_OFF_AUTOCNT: PRDATA_O[AUTO_CNT_W-1:0] <= auto_cnt_load;
				default: PRDATA_O <= 32'h0000_0000;
			endcase
		end
	end

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;
endmodule // adcsc_top
`default_nettype wire

/* File: test/adcsc_core_model.sv */
// Purpose: behavioural converter core answering each start with a done
// Assumes: one conversion at a time, LAT cycles each
// Notes:   result lines invert their value every cycle outside the done cycle
`timescale 1ns/1ns
`default_nettype none
module adcsc_core_model #(
	parameter int LAT = 8
) (
	// control
	input  wire logic        clk_i,
	input  wire logic        start_i,
	input  wire logic [11:0] val_i,
	// answer
	output logic             done_o,
	output logic      [11:0] res_o
);
	int cnt = 0;
	initial begin
		done_o = 1'b0;
		res_o = 12'h000;
	end
	// stale result is scrambled so a late sample cannot pass by luck
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		res_o <= ~res_o;
		if (start_i) begin
			cnt <= LAT;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1) begin
				done_o <= 1'b1;
				res_o <= val_i;
			end
		end
	end
endmodule // adcsc_core_model
`default_nettype wire

/* File: test/adcsc_top_checker.sv */
// Purpose: port-level assertions for the sample/convert control block
// Assumes: bound to adcsc_top
// Notes:   conversions last several cycles, so starts never abut
`timescale 1ns/1ns
`default_nettype none
module adcsc_top_checker (
	// watched ports
	input wire logic                               CLK_I,
	input wire logic                               RST_B_I,
	input wire logic                               PSEL_I,
	input wire logic                               PENABLE_I,
	input wire logic [adcsc_pkg::ADCSC_ADDR_W-1:0] PADDR_I,
	input wire logic                               PSLVERR_O,
	input wire logic [adcsc_pkg::ADCSC_NUM_CH-1:0] SH_ACQUIRE_O,
	input wire logic                               CONV_START_O,
	input wire logic [1:0]                         CONV_CH_O,
	input wire logic                               CONV_DONE_I
);
	import adcsc_pkg::*;
	logic [1:0] last_ch;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			last_ch <= 2'h0;
		else if (CONV_START_O)
			last_ch <= CONV_CH_O;
	end
	////////////////////////////////////////////////////////////////////
	property p_sh_shape;
		SH_ACQUIRE_O inside {4'h0, 4'h1, 4'h3, 4'hf};
	endproperty
	a_sh_shape: assert property (p_sh_shape)
		else $error("acquire pattern not a legal channel group");
	property p_start_once;
		CONV_START_O && !CONV_DONE_I |=> !CONV_START_O;
	endproperty
	a_start_once: assert property (p_start_once)
		else $error("trigger start lasted more than one cycle");
	property p_start_first;
		CONV_START_O && !CONV_DONE_I |-> CONV_CH_O == 2'h0;
	endproperty
	a_start_first: assert property (p_start_first)
		else $error("first conversion not on channel a");
	property p_chain_next;
		CONV_START_O && CONV_DONE_I |-> CONV_CH_O == last_ch + 2'h1;
	endproperty
	a_chain_next: assert property (p_chain_next)
		else $error("chained conversion skipped a channel");
	property p_hold_after;
		CONV_START_O |-> ##2 SH_ACQUIRE_O == 4'h0;
	endproperty
	a_hold_after: assert property (p_hold_after)
		else $error("amplifiers still acquiring during conversion");
	property p_err_map;
		PSEL_I && PENABLE_I && PADDR_I > ADCSC_OFF_AUTOCNT |-> PSLVERR_O;
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("unmapped access not flagged");
	property p_err_ok;
		PSEL_I && PENABLE_I && PADDR_I <= ADCSC_OFF_AUTOCNT
			&& PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O;
	endproperty
	a_err_ok: assert property (p_err_ok)
		else $error("mapped access flagged as error");
	property p_err_only;
		PSLVERR_O |-> PSEL_I && PENABLE_I;
	endproperty
	a_err_only: assert property (p_err_only)
		else $error("error flag outside an access phase");
endmodule // adcsc_top_checker
bind adcsc_top adcsc_top_checker u_chk (
	.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PSLVERR_O(PSLVERR_O),
	.SH_ACQUIRE_O(SH_ACQUIRE_O), .CONV_START_O(CONV_START_O),
	.CONV_CH_O(CONV_CH_O), .CONV_DONE_I(CONV_DONE_I)
);
`default_nettype wire

/* File: test/adcsc_top_tb.sv */
// Purpose: self-checking bench for the sample/convert control block
// Assumes: zero-wait APB slave, core model with fixed latency
// Notes:   each scenario is one task
`timescale 1ns/1ns
`default_nettype none
module adcsc_top_tb;
	import adcsc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic [2:0]  src = 3'h0;
	logic [3:0]  sh;
	logic        cstart;
	logic [1:0]  cch;
	logic        cdone;
	logic [11:0] cres;
	logic [11:0] raw = 12'h000;
	logic [31:0] rd;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          n_start = 0;
	logic [1:0]  start_ch = 2'h0;
	always #5 clk = ~clk;
	// starts are comb pulses; count them where they are settled
	always @(negedge clk)
		if (cstart === 1'b1) begin
			n_start++;
			start_ch = cch;
		end
	adcsc_top u_dut (
		.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(),
		.EXT_TRIG_PIN_I(src[0]), .TIMER_C_CMP_I(src[1]),
		.TIMER_E_CMP_I(src[2]), .SH_ACQUIRE_O(sh), .CONV_START_O(cstart),
		.CONV_CH_O(cch), .CONV_DONE_I(cdone), .CONV_RESULT_I(cres)
	);
	adcsc_core_model u_core (
		.clk_i(clk), .start_i(cstart), .val_i(raw),
		.done_o(cdone), .res_o(cres)
	);
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic fire(input logic [2:0] m);
		@(posedge clk);
		src <= m;
		@(posedge clk);
		src <= 3'h0;
	endtask
	task automatic wait_start(input int want, input int lim,
			output logic seen);
		for (int i = 0; i < lim && n_start < want; i++)
			@(negedge clk);
		seen = (n_start >= want);
	endtask
	task automatic wait_done;
		for (int i = 0; i < 30; i++) begin
			apb(1'b0, ADCSC_OFF_CTRL1, 32'h0);
			if (rd[0] === 1'b1)
				break;
		end
		chk(rd[0], 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		apb(1'b0, ADCSC_OFF_CTRL1, 32'h0);
		chk(rd, {16'h0, ADCSC_RESET_VAL});
		apb(1'b0, ADCSC_OFF_AUTOCNT, 32'h0);
		chk(rd, {24'h0, ADCSC_AUTOCNT_RST});
		apb(1'b1, 12'h010, 32'hffff);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_format;
		logic [11:0] v;
		logic [15:0] ex;
		logic [15:0] m;
		for (int t = 0; t < 2; t++)
			for (int f = 0; f < 3; f++)
				for (int r = 0; r < 2; r++) begin
					v = r ? 12'h15a : 12'hd5a;
					raw <= v;
					// sw trigger, simultaneous bit set, sample on
					apb(1'b1, ADCSC_OFF_CTRL1, {21'h0, t[0], f[1:0], 8'h0a});
					apb(1'b0, ADCSC_OFF_CTRL1, 32'h0);
					chk(rd[10:0], {t[0], f[1:0], t ? 8'h02 : 8'h0a});
					apb(1'b1, ADCSC_OFF_CTRL1, {21'h0, t[0], f[1:0], 8'h08});
					wait_done;
					chk(rd[1], 32'h0);
					if (t)
						ex = {f == 1 ? {4{~v[11]}} : 4'h0, v};
					else
						ex = {f == 1 ? {6{~v[9]}} : 6'h0, v[9:0]};
					m = (t == 0 && f == 1) ? 16'hfdff : 16'hffff;
					apb(1'b0, ADCSC_OFF_RESULT, 32'h0);
					chk(rd[15:0] & m, ex & m);
				end
		apb(1'b1, ADCSC_OFF_CTRL1, 32'h0);
		apb(1'b1, ADCSC_OFF_CTRL1, 32'h1);
		apb(1'b0, ADCSC_OFF_CTRL1, 32'h0);
		chk(rd[1:0], 32'h0);
		chk(sh, 32'h0);
	endtask
	task automatic t_trig;
		logic       s;
		int         n0;
		logic [2:0] c [4] = '{ADCSC_TRIG_PIN, ADCSC_TRIG_TMR_C,
			ADCSC_TRIG_TMR_E, ADCSC_TRIG_AUTO};
		// auto count long enough to outlast the wrong-source probe
		apb(1'b1, ADCSC_OFF_AUTOCNT, 32'h14);
		foreach (c[i]) begin
			apb(1'b1, ADCSC_OFF_CTRL1, {24'h0, c[i], 5'h02});
			apb(1'b0, ADCSC_OFF_CTRL1, 32'h0);
			chk(rd[1], 32'h1);
			chk(sh, 32'h1);
			n0 = n_start;
			fire(c[i] == ADCSC_TRIG_AUTO ? 3'h7 : ~c[i]);
			wait_start(n0 + 1, 4, s);
			chk(s, 32'h0);
			n0 = n_start;
			fire(c[i] == ADCSC_TRIG_AUTO ? 3'h0 : c[i]);
			wait_start(n0 + 1, 30, s);
			chk(s, 32'h1);
			apb(1'b0, ADCSC_OFF_CTRL1, 32'h0);
			chk(rd[1:0], 32'h0);
			wait_done;
		end
	endtask
	task automatic t_auto;
		logic       s;
		logic [1:0] cnt [3] = '{2'h3, 2'h3, 2'h1};
		logic [3:0] shx [3] = '{4'h1, 4'hf, 4'h3};
		int         n [3] = '{4, 4, 2};
		int         n0;
		foreach (cnt[k]) begin
			apb(1'b1, ADCSC_OFF_CTRL2, {22'h0, cnt[k], 8'h0});
			apb(1'b1, ADCSC_OFF_CTRL1,
				{24'h0, ADCSC_TRIG_TMR_C, 1'b0, k != 0, 3'h6});
			n0 = n_start;
			fire(3'h2);
			for (int i = 0; i < n[k]; i++) begin
				wait_start(n0 + i + 1, 40, s);
				chk(s, 32'h1);
				chk(start_ch, i);
				@(posedge clk);
			end
			repeat (12) @(posedge clk);
			chk(sh, shx[k]);
			apb(1'b0, ADCSC_OFF_CTRL1, 32'h0);
			chk(rd[1:0], 32'h3);
		end
		apb(1'b1, ADCSC_OFF_CTRL1, 32'h0);
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		t_regs;
		t_format;
		t_trig;
		t_auto;
		print_verdict;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		print_verdict;
	end
endmodule // adcsc_top_tb
`default_nettype wire
